/* File: psensor_pkg.sv */
// Package: constants and carriers for the sensor command target.
// Assumes a single 200 MHz clock domain; bus pins are synchronised.
package psensor_pkg;
  localparam logic [6:0]  TARGET_ADDR  = 7'h76;
  localparam logic [7:0]  CMD_RESET    = 8'h1e;
  localparam logic [7:0]  CMD_READ_ADC = 8'h00;
  localparam logic [3:0]  CMD_CONVERSION_SELECT_BIT_HI  = 4'h4;
  localparam logic [3:0]  CMD_PROM_HI  = 4'ha;
  localparam int          CLK_MHZ      = 200;
  // Maximum conversion times in microseconds, one per ratio
  localparam int CONVERSION_SELECT_BIT_US [6] = '{560, 1100, 2170, 4320, 8610, 17200};
  localparam logic [23:0] RESULT_RESET = 24'h000000;
  localparam logic [2:0]  PROM_WORDS   = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b011,
    ST_WDAT = 3'b010,
    ST_WACK = 3'b110,
    ST_RDAT = 3'b111,
    ST_RACK = 3'b101,
    ST_SKIP = 3'b100
  } bus_state_e;

  typedef enum logic [1:0] {
    SRC_NONE = 2'h0,
    SRC_ADC  = 2'h1,
    SRC_PROM = 2'h2
  } read_src_e;

  typedef struct packed {
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
  } pins_s;

  typedef struct packed {
    pins_s       pins;
    bus_state_e  state;
    logic [7:0]  shift;
    logic [3:0]  bitcnt;
    logic        rw;
    read_src_e   src;
    logic [1:0]  bytes_left;
    logic [23:0] out_data;
    logic [2:0]  prom_idx;
    logic        prom_loaded;
    logic        busy;
    logic [22:0] conversion_select_bit_cnt;
    logic        conversion_select_bit_type;
    logic        conversion_select_bit_bad;
    logic [23:0] result;
    logic        result_valid;
    logic        sda_oe_n;
    logic        busy_out;
    logic        start_pulse;
    logic        meas_out;
  } state_s;
endpackage

/* File: psensor_cmd.sv */
// Command target for the pressure/temperature sensor on an I2C-style bus.
// Assumes SCL and SDA come from the host asynchronously; sampling 200 MHz.
// Contract
// - Respond at address 1110110, R/W bit last
// - One eight-bit command byte per write
// - Reset command reloads calibration words
// - Reset accepted at any time, restores state
// - 0x40..0x4A start pressure conversion, ratio
// - 0x50..0x5A start temperature conversion, ratio
// - Command 0x00 then read gives 24 bits
// - 0xA0..0xAC pick word by index bits
// - Seven sixteen-bit calibration words held
// - Calibration read returns 16 bits, MSB first
// - No conversion or repeated read gives zero
// - Read during conversion: zero, result corrupted
// - Busy until conversion finishes, then valid
// - Result 24 bits MSB first after ack
// - Only clock and shared data line used
module psensor_cmd #(
  parameter int          CONVERSION_SELECT_BIT_SCALE = 1,
  parameter logic [15:0] PROM_W0    = 16'h0000,
  parameter logic [15:0] PROM_W1    = 16'h1111,
  parameter logic [15:0] PROM_W2    = 16'h2222,
  parameter logic [15:0] PROM_W3    = 16'h3333,
  parameter logic [15:0] PROM_W4    = 16'h4444,
  parameter logic [15:0] PROM_W5    = 16'h5555,
  parameter logic [15:0] PROM_W6    = 16'h6666
) (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        SCL,
  input  wire logic        SDA_IN,
  output logic             SDA_OE_N,
  output logic             CONVERSION_SELECT_BIT_BUSY,
  output logic             CONVERSION_SELECT_BIT_START,
  output logic             MEASURAND
);

  psensor_pkg::state_s     r;
  psensor_pkg::state_s     next_r;
  logic [15:0]             nvm [7];
  logic [15:0]             shadow [7];
  logic [22:0]             conversion_select_bit_cycles [6];
  logic                    scl_rise;
  logic                    scl_fall;
  logic                    start_cond;
  logic                    stop_cond;
  logic [23:0]             raw_sample;
  logic [7:0]              cmd;
  logic                    load_shadow;

  assign nvm[0] = PROM_W0;
  assign nvm[1] = PROM_W1;
  assign nvm[2] = PROM_W2;
  assign nvm[3] = PROM_W3;
  assign nvm[4] = PROM_W4;
  assign nvm[5] = PROM_W5;
  assign nvm[6] = PROM_W6;

  // Per-ratio conversion length in cycles
  for (genvar i = 0; i < 6; i++) begin : g_conversion_select_bit
    assign conversion_select_bit_cycles[i] = 23'(psensor_pkg::CONVERSION_SELECT_BIT_US[i]
                            * psensor_pkg::CLK_MHZ / CONVERSION_SELECT_BIT_SCALE);
  end

  // Calibration shadow registers, reloaded by the reset command
  for (genvar i = 0; i < 7; i++) begin : g_shadow
    always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        shadow[i] <= 16'h0000;
      end else if (load_shadow) begin
        shadow[i] <= nvm[i];
      end
    end
  end

  // Synchroniser taps read only from the second stage onward
  assign scl_rise   = r.pins.scl_sync[1] & ~r.pins.scl_sync[2];
  assign scl_fall   = ~r.pins.scl_sync[1] & r.pins.scl_sync[2];
  assign start_cond = r.pins.scl_sync[2] & r.pins.scl_sync[1]
                      & r.pins.sda_sync[2] & ~r.pins.sda_sync[1];
  assign stop_cond  = r.pins.scl_sync[2] & r.pins.scl_sync[1]
                      & ~r.pins.sda_sync[2] & r.pins.sda_sync[1];
  assign cmd        = r.shift;
  assign raw_sample = {r.conversion_select_bit_type, 3'h0, r.conversion_select_bit_cnt[19:0]};
  assign load_shadow = r.state == psensor_pkg::ST_WACK && scl_fall
                       && cmd == psensor_pkg::CMD_RESET;

  always_comb begin
    next_r = r;
    next_r.pins.scl_sync = {r.pins.scl_sync[1:0], SCL};
    next_r.pins.sda_sync = {r.pins.sda_sync[1:0], SDA_IN};
    next_r.start_pulse = 1'b0;
    // Conversion timer
    if (r.busy) begin
      if (r.conversion_select_bit_cnt == 23'h000000) begin
        next_r.busy = 1'b0;
        next_r.result = r.conversion_select_bit_bad ? 24'hffffff : raw_sample;
        next_r.result_valid = 1'b1;
      end else begin
        next_r.conversion_select_bit_cnt = r.conversion_select_bit_cnt - 23'h000001;
      end
    end
    case (r.state)
      psensor_pkg::ST_IDLE: begin
        next_r.sda_oe_n = 1'b1;
      end
      psensor_pkg::ST_ADDR, psensor_pkg::ST_WDAT: begin
        if (scl_rise) begin
          next_r.shift  = {r.shift[6:0], r.pins.sda_sync[2]};
          next_r.bitcnt = r.bitcnt + 4'h1;
        end
        if (scl_fall && r.bitcnt == 4'h8) begin
          next_r.bitcnt = 4'h0;
          if (r.state == psensor_pkg::ST_WDAT) begin
            next_r.state = psensor_pkg::ST_WACK;
            next_r.sda_oe_n = 1'b0;
          end else if (r.shift[7:1] == psensor_pkg::TARGET_ADDR) begin
            next_r.state = psensor_pkg::ST_AACK;
            next_r.rw = r.shift[0];
            next_r.sda_oe_n = 1'b0;
          end else begin
            next_r.state = psensor_pkg::ST_SKIP;
          end
        end
      end
      psensor_pkg::ST_AACK: begin
        if (scl_fall) begin
          if (r.rw) begin
            next_r.state = psensor_pkg::ST_RDAT;
            next_r.bytes_left = (r.src == psensor_pkg::SRC_PROM)
                                ? 2'h1 : 2'h2;
            if (r.src == psensor_pkg::SRC_ADC) begin
              // Busy, absent or repeated result reads as zero
              next_r.out_data = (r.busy || !r.result_valid)
                                ? psensor_pkg::RESULT_RESET
                                : r.result;
              if (!r.busy) begin
                // A finishing conversion keeps its valid flag
                next_r.result_valid = 1'b0;
              end
              next_r.conversion_select_bit_bad = r.busy;
            end else if (r.src == psensor_pkg::SRC_PROM) begin
              next_r.out_data = {shadow[r.prom_idx], 8'h00};
            end else begin
              next_r.out_data = psensor_pkg::RESULT_RESET;
            end
            next_r.src = psensor_pkg::SRC_NONE;
            // First bit leaves with the word it heads
            next_r.sda_oe_n = next_r.out_data[23];
          end else begin
            next_r.state = psensor_pkg::ST_WDAT;
            next_r.sda_oe_n = 1'b1;
          end
        end
      end
      psensor_pkg::ST_WACK: begin
        if (scl_fall) begin
          next_r.state = psensor_pkg::ST_SKIP;
          next_r.sda_oe_n = 1'b1;
          if (cmd == psensor_pkg::CMD_RESET) begin
            next_r.busy = 1'b0;
            next_r.result_valid = 1'b0;
            next_r.conversion_select_bit_bad = 1'b0;
            next_r.src = psensor_pkg::SRC_NONE;
            next_r.prom_loaded = 1'b1;
          end else if (cmd[7:4] == psensor_pkg::CMD_CONVERSION_SELECT_BIT_HI
                       || cmd[7:4] == 4'h5) begin
            if (!cmd[0] && cmd[3:1] < 3'h6) begin
              next_r.conversion_select_bit_type = cmd[4];
              next_r.conversion_select_bit_cnt = conversion_select_bit_cycles[cmd[3:1]];
              next_r.conversion_select_bit_bad = r.busy;
              next_r.busy = 1'b1;
              next_r.result_valid = 1'b0;
              next_r.start_pulse = 1'b1;
            end
          end else if (cmd == psensor_pkg::CMD_READ_ADC) begin
            next_r.src = psensor_pkg::SRC_ADC;
          end else if (cmd[7:4] == psensor_pkg::CMD_PROM_HI && !cmd[0]
                       && cmd[3:1] < psensor_pkg::PROM_WORDS) begin
            next_r.src = psensor_pkg::SRC_PROM;
            next_r.prom_idx = cmd[3:1];
          end
        end
      end
      psensor_pkg::ST_RDAT: begin
        if (scl_fall) begin
          next_r.bitcnt = r.bitcnt + 4'h1;
          next_r.out_data = {r.out_data[22:0], 1'b0};
          if (r.bitcnt == 4'h7) begin
            next_r.state = psensor_pkg::ST_RACK;
            next_r.bitcnt = 4'h0;
            next_r.sda_oe_n = 1'b1;
          end else begin
            next_r.sda_oe_n = r.out_data[22];
          end
        end
      end
      psensor_pkg::ST_RACK: begin
        if (scl_rise) begin
          next_r.rw = r.pins.sda_sync[2];
        end
        if (scl_fall) begin
          if (!r.rw && r.bytes_left != 2'h0) begin
            next_r.state = psensor_pkg::ST_RDAT;
            next_r.bytes_left = r.bytes_left - 2'h1;
            next_r.sda_oe_n = r.out_data[23];
          end else begin
            next_r.state = psensor_pkg::ST_SKIP;
          end
        end
      end
      psensor_pkg::ST_SKIP: begin
        next_r.sda_oe_n = 1'b1;
      end
      default: begin
        next_r.state = psensor_pkg::ST_IDLE;
        next_r.sda_oe_n = 1'b1;
      end
    endcase
    if (stop_cond) begin
      next_r.state = psensor_pkg::ST_IDLE;
      next_r.sda_oe_n = 1'b1;
    end
    if (start_cond) begin
      next_r.state = psensor_pkg::ST_ADDR;
      next_r.bitcnt = 4'h0;
      next_r.sda_oe_n = 1'b1;
    end
    next_r.busy_out = next_r.busy;
    next_r.meas_out = next_r.conversion_select_bit_type;
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      r <= '0;
      r.pins.scl_sync <= 3'h7;
      r.pins.sda_sync <= 3'h7;
      r.sda_oe_n <= 1'b1;
      r.state <= psensor_pkg::ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign SDA_OE_N   = r.sda_oe_n;
  assign CONVERSION_SELECT_BIT_BUSY  = r.busy_out;
  assign CONVERSION_SELECT_BIT_START = r.start_pulse;
  assign MEASURAND  = r.meas_out;

  sequence s_reset_cmd;
    r.state == psensor_pkg::ST_WACK && scl_fall
    && cmd == psensor_pkg::CMD_RESET;
  endsequence

  a_reset_clears_busy: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_reset_cmd |=> !r.busy && r.prom_loaded)
    else $error("reset command left device busy");
  a_reset_loads_prom: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_reset_cmd |=> ##1 shadow[1] == PROM_W1)
    else $error("calibration not reloaded");
  a_conversion_select_bit_sets_busy: assert property (@(posedge CLK) disable iff (!RESET_N)
    $rose(CONVERSION_SELECT_BIT_START) |-> CONVERSION_SELECT_BIT_BUSY)
    else $error("conversion start without busy");
  a_conversion_select_bit_cmd_start: assert property (@(posedge CLK) disable iff (!RESET_N)
    r.state == psensor_pkg::ST_WACK && scl_fall && cmd == 8'h4a
    |=> r.start_pulse && r.conversion_select_bit_type == 1'b0)
    else $error("pressure command not started");
  a_temp_cmd_type: assert property (@(posedge CLK) disable iff (!RESET_N)
    r.state == psensor_pkg::ST_WACK && scl_fall && cmd == 8'h50
    |=> r.conversion_select_bit_type)
    else $error("temperature command wrong type");
  a_busy_read_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
    r.state == psensor_pkg::ST_AACK && scl_fall && r.rw && r.busy
    && r.src == psensor_pkg::SRC_ADC |=> r.out_data == 24'h0)
    else $error("read during conversion not zero");
  a_repeat_read_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
    r.state == psensor_pkg::ST_AACK && scl_fall && r.rw
    && !r.busy && r.src == psensor_pkg::SRC_ADC |=> !r.result_valid)
    else $error("result still valid after read");
  a_addr_ack: assert property (@(posedge CLK) disable iff (!RESET_N)
    r.state == psensor_pkg::ST_AACK |-> $past(r.shift[7:1])
    == psensor_pkg::TARGET_ADDR || $past(r.state) == r.state)
    else $error("acked wrong address");
  a_ack_drive_low: assert property (@(posedge CLK) disable iff (!RESET_N)
    r.state == psensor_pkg::ST_WACK && !stop_cond && !start_cond
    |-> !SDA_OE_N || $past(r.state) == psensor_pkg::ST_WACK)
    else $error("command byte not acknowledged");
  a_rack_release: assert property (@(posedge CLK) disable iff (!RESET_N)
    r.state == psensor_pkg::ST_RACK |-> SDA_OE_N)
    else $error("device drove line during host ack");

endmodule // psensor_cmd

/* File: psensor_host.sv */
// Host model: bus controller that frames transfers on SCL and SDA.
// Assumes the bench resolves SDA as an open-drain wire with pull-up.
module psensor_host (
  input  wire logic       clk,
  input  wire logic       sda,
  output logic            scl,
  output logic            sda_oe_n,
  output logic            rx_valid,
  output logic [7:0]      rx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 10;

  initial begin
    scl = 1'b1;
    sda_oe_n = 1'b1;
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic start_cond();
    sda_oe_n = 1'b1;
    scl = 1'b1;
    wait_n(HALF);
    sda_oe_n = 1'b0;
    wait_n(HALF);
    scl = 1'b0;
    wait_n(HALF / 2);
  endtask

  task automatic stop_cond();
    sda_oe_n = 1'b0;
    wait_n(HALF / 2);
    scl = 1'b1;
    wait_n(HALF);
    sda_oe_n = 1'b1;
    wait_n(HALF);
  endtask

  // One clock pulse; a one releases the wire so the target can drive it
  task automatic put_bit(input logic b, output logic got);
    sda_oe_n = b;
    wait_n(HALF / 2);
    scl = 1'b1;
    wait_n(HALF);
    got = sda;
    scl = 1'b0;
    wait_n(HALF / 2);
  endtask

  task automatic emit(input logic [7:0] v);
    rx_data = v;
    rx_valid = 1'b1;
    wait_n(1);
    rx_valid = 1'b0;
  endtask

  // Frees a held data line: nine clocks with the wire released
  task automatic recover();
    logic g;
    for (int i = 0; i < 9; i++) put_bit(1'b1, g);
    emit({7'h00, g});
  endtask

  task automatic wr_byte(input logic [7:0] v);
    logic g;
    for (int i = 7; i >= 0; i--) put_bit(v[i], g);
    put_bit(1'b1, g);
    emit({7'h00, g});
  endtask

  task automatic rd_byte(input logic last);
    logic [7:0] v;
    logic       g;
    for (int i = 7; i >= 0; i--) put_bit(1'b1, v[i]);
    put_bit(last, g);
    emit(v);
  endtask
endmodule // psensor_host

/* File: psensor_cmd_tb.sv */
// Bench: drives the sensor command target through the host model.
// Assumes open-drain SDA with pull-up and scaled conversion times.
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  miscompares++; \
  $display("unexpected at %0t got %h exp %h", $time, (a), (b)); end end

module psensor_cmd_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SCALE = 1000;
  localparam logic [15:0] W [7] = '{16'h3c1a, 16'h81f4, 16'h7e02,
                                    16'h5a96, 16'h0c3d, 16'hd271, 16'h49e8};
  logic       clk;
  logic       reset_n;
  logic       sda;
  logic       scl;
  logic       host_oe_n;
  logic       sda_oe_n;
  logic       busy;
  logic       conversion_select_bit_start;
  logic       measurand;
  logic       rx_valid;
  logic [7:0] rx_data;
  logic [7:0] exp_q[$];
  logic [7:0] msk_q[$];
  logic [7:0] m;
  logic [7:0] e;
  int         miscompares = 0;
  int         comparisons = 0;
  int         starts = 0;
  int         busy_len = 0;

  assign sda = host_oe_n & sda_oe_n;
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  psensor_cmd #(.CONVERSION_SELECT_BIT_SCALE(SCALE), .PROM_W0(W[0]), .PROM_W1(W[1]),
    .PROM_W2(W[2]), .PROM_W3(W[3]), .PROM_W4(W[4]), .PROM_W5(W[5]),
    .PROM_W6(W[6])) dut (.CLK(clk), .RESET_N(reset_n), .SCL(scl),
    .SDA_IN(sda), .SDA_OE_N(sda_oe_n), .CONVERSION_SELECT_BIT_BUSY(busy),
    .CONVERSION_SELECT_BIT_START(conversion_select_bit_start), .MEASURAND(measurand));

  psensor_host host (.clk(clk), .sda(sda), .scl(scl), .sda_oe_n(host_oe_n),
    .rx_valid(rx_valid), .rx_data(rx_data));

  always @(posedge clk) begin
    if (conversion_select_bit_start === 1'b1) begin
      starts++;
      busy_len = 0;
    end else if (busy === 1'b1) begin
      busy_len++;
    end
  end

  // Oldest note against each byte or acknowledge the host collects
  always @(posedge clk) begin
    if (rx_valid === 1'b1) begin
      m = msk_q.size() ? msk_q.pop_front() : 8'hff;
      e = exp_q.size() ? exp_q.pop_front() : 8'hxx;
      `CHK(rx_data & m, e & m)
    end
  end

  task automatic end_sim();
    if (miscompares == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic note(input logic [7:0] ev, input logic [7:0] mv);
    exp_q.push_back(ev);
    msk_q.push_back(mv);
  endtask

  task automatic cmd(input logic [7:0] c);
    note(8'h00, 8'hff);
    note(8'h00, 8'hff);
    host.start_cond();
    host.wr_byte({psensor_pkg::TARGET_ADDR, 1'b0});
    host.wr_byte(c);
    host.stop_cond();
  endtask

  task automatic rd(input int n, input logic [23:0] ev,
                    input logic [23:0] mv);
    note(8'h00, 8'hff);
    host.start_cond();
    host.wr_byte({psensor_pkg::TARGET_ADDR, 1'b1});
    for (int i = n - 1; i >= 0; i--) begin
      note(ev[8*i +: 8], mv[8*i +: 8]);
      host.rd_byte(i == 0);
    end
    host.stop_cond();
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 5000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 5000) begin
      miscompares++;
      end_sim();
    end
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    end_sim();
  end

  initial begin
    logic [6:0] a;
    logic [7:0] c;
    int         t;
    int         r;
    int         lim;
    int         s0;
    reset_n = 1'b0;
    void'($urandom(32'h47fe));
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    repeat (10) @(negedge clk);
    cmd(8'ha2);
    rd(2, 24'h0, 24'hffff);
    cmd(psensor_pkg::CMD_RESET);
    for (int k = 0; k < 7; k++) begin
      cmd(8'ha0 | 8'(k << 1));
      rd(2, {8'h00, W[k]}, 24'hffff);
    end
    t = $urandom_range(6);
    cmd(8'ha0 | 8'(t << 1));
    rd(3, {W[t], 8'hff}, 24'hffffff);
    cmd(psensor_pkg::CMD_READ_ADC);
    rd(3, 24'h0, 24'hffffff);
    a = 7'($urandom_range(127));
    if (a == psensor_pkg::TARGET_ADDR) a = 7'h2b;
    note(8'h01, 8'hff);
    note(8'h01, 8'hff);
    s0 = starts;
    host.start_cond();
    host.wr_byte({a, 1'b0});
    host.wr_byte(8'h48);
    host.stop_cond();
    `CHK(starts, s0)
    for (int i = 0; i < 12; i++) begin
      t = i / 6;
      r = i % 6;
      c = 8'h40 + 8'(t * 16 + r * 2);
      s0 = starts;
      cmd(c);
      `CHK(starts, s0 + 1)
      `CHK(measurand, t[0])
      `CHK(busy, 1'b1)
      wait_idle();
      lim = psensor_pkg::CONVERSION_SELECT_BIT_US[r] * 200 / SCALE;
      `CHK(busy_len >= lim - 2 && busy_len <= lim + 4, 1'b1)
      cmd(psensor_pkg::CMD_READ_ADC);
      rd(3, {t[0], 23'h0}, 24'hf00000);
      cmd(psensor_pkg::CMD_READ_ADC);
      rd(3, 24'h0, 24'hffffff);
    end
    cmd(8'h4a);
    cmd(psensor_pkg::CMD_READ_ADC);
    rd(3, 24'h0, 24'hffffff);
    wait_idle();
    cmd(psensor_pkg::CMD_READ_ADC);
    rd(3, 24'hffffff, 24'hffffff);
    cmd(8'h58);
    cmd(psensor_pkg::CMD_RESET);
    `CHK(busy, 1'b0)
    cmd(psensor_pkg::CMD_READ_ADC);
    rd(3, 24'h0, 24'hffffff);
    note(8'h00, 8'hff);
    note(8'h01, 8'hff);
    host.start_cond();
    host.wr_byte({psensor_pkg::TARGET_ADDR, 1'b1});
    host.recover();
    cmd(psensor_pkg::CMD_RESET);
    cmd(8'ha2);
    rd(2, {8'h00, W[1]}, 24'hffff);
    repeat (20) @(negedge clk);
    end_sim();
  end
endmodule // psensor_cmd_tb
